// ===== iotg_cfg.svh
// offsets, field positions and reset values of the gearbox register block
// assumes 32-bit apb data with one aligned word per register
`ifndef IOTG_CFG_SVH
`define IOTG_CFG_SVH

// register byte offsets
`define IOTG_CTRL_OFS 8'h00
`define IOTG_STAT_OFS 8'h04
`define IOTG_WCNT_OFS 8'h08

// control fields
`define IOTG_CTRL_MODE_LSB 0
`define IOTG_CTRL_MODE_MSB 1
`define IOTG_CTRL_MEM_BIT 2
`define IOTG_CTRL_MODE_RST 2'h1
`define IOTG_CTRL_MEM_RST 1'h0

// status fields
`define IOTG_STAT_OVR_BIT 0
`define IOTG_STAT_LVL_LSB 4

// datapath sizes
`define IOTG_WORD_W 8
`define IOTG_FIFO_DEPTH 8
`define IOTG_WCNT_W 16

`endif

// ===== iotg_pkg.sv
// types shared by the input gearbox and its register block
// assumes iotg_cfg.svh sits in the include path
package iotg_pkg;

  // deserializer arrangement
  typedef enum logic [1:0]
  {
    MODE_SEVEN_TO_ONE = 2'b00,
    MODE_EIGHT_TO_ONE = 2'b01,
    MODE_FOUR_TO_ONE = 2'b10
  } iotg_mode_t;

endpackage

// ===== iotg_gearbox.sv
// tri-state register stage and 1:7 / 1:8 / dual 1:4 input gearbox
// assumes pins arrive asynchronous to clk; core signals are on clk
`timescale 1ns/1ps
`default_nettype none
`include "iotg_cfg.svh"

////////////////////////////////////////////////////////////////////////////
// word fifo between the gearbox and the core port

module iotg_fifo
  #(
    parameter int WIDTH = `IOTG_WORD_W,
    parameter int DEPTH = `IOTG_FIFO_DEPTH
  )
  (
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    input wire logic clear,
    // fill side
    input wire logic inValid,
    output logic inReady,
    input wire logic [WIDTH-1:0] inData,
    // drain side
    output logic outValid,
    input wire logic outReady,
    output logic [WIDTH-1:0] outData,
    output logic [$clog2(DEPTH+1)-1:0] level
  );

  localparam int PW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH+1);
  localparam logic [CW-1:0] FULL = CW'(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0] wrPtr_q;
  logic [PW-1:0] rdPtr_q;
  logic [CW-1:0] count_q;
  logic push;
  logic pop;

  // depth is a power of two so pointers wrap on their own
  assign inReady = (count_q != FULL);
  assign outValid = (count_q != '0);
  assign outData = mem[rdPtr_q];
  assign level = count_q;
  assign push = inValid & inReady;
  assign pop = outValid & outReady;

  // storage, no reset needed on data
  always_ff @(posedge clk)
  begin
    if (push)
      mem[wrPtr_q] <= inData;
  end

  // pointers and fill count
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
      count_q <= '0;
    end
    else if (clear)
    begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
      count_q <= '0;
    end
    else
    begin
      if (push)
        wrPtr_q <= wrPtr_q + 1'b1;
      if (pop)
        rdPtr_q <= rdPtr_q + 1'b1;
      if (push && !pop)
        count_q <= count_q + 1'b1;
      else if (pop && !push)
        count_q <= count_q - 1'b1;
    end
  end

endmodule

////////////////////////////////////////////////////////////////////////////
// top: tri-state stage, deserializer, apb registers

// What this block does
// RULE1: tri-state control registered before pad buffer
// RULE2: single rate: one flop drives tri-state
// RULE3: right edge memory mode uses strobe register
// RULE4: each bottom cell group has 1:8 gearbox
// RULE5: modes 1:7, 1:8, or dual 1:4
// RULE6: serial input is delayed pad data
// RULE7: 1:7 word on bits six to zero
// RULE8: 1:8 word on bits seven to zero
// RULE9: dual 1:4 upper lane on bits 4-7
// RULE10: dual 1:4 lower lane on bits 0-3
// RULE11: core align pulse shifts word boundary
// RULE12: bits in on edge clock, words out slow
// RULE13: gearbox reset clears state, zeroes outputs; the sticky overrun flag is not cleared by it
module iotg_gearbox
  import iotg_pkg::*;
  #(
    parameter bit RIGHT_EDGE = 1'b1,
    parameter int WORD_W = `IOTG_WORD_W,
    parameter int FIFO_DEPTH = `IOTG_FIFO_DEPTH
  )
  (
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // tri-state path from core to pad buffer
    input wire logic tristateCtrlIn,
    input wire logic memoryModeTristateIn,
    input wire logic writeStrobeQuarterPhase,
    output logic padTristate,
    // serial pins after the input delay
    input wire logic fastEdgeClock,
    input wire logic upperHalfLane,
    input wire logic lowerHalfLane,
    // core side of the gearbox
    input wire logic wordAlignPulse,
    input wire logic gearboxRst,
    output logic [WORD_W-1:0] parWord,
    output logic parValid,
    input wire logic parReady
  );

  localparam int LW = $clog2(FIFO_DEPTH+1);

  // deserialization ratio of a mode, unused code acts as 1:8
  function automatic logic [3:0] ratioOf(input iotg_mode_t m);
    case (m)
      MODE_SEVEN_TO_ONE: ratioOf = 4'd7;
      MODE_FOUR_TO_ONE: ratioOf = 4'd4;
      default: ratioOf = 4'd8;
    endcase
  endfunction

  // place lane bits on the parallel word for a mode
  function automatic logic [7:0] packWord(input iotg_mode_t m,
                                          input logic [7:0] up,
                                          input logic [3:0] lo);
    case (m)
      MODE_SEVEN_TO_ONE: packWord = {1'b0, up[6:0]}; // RULE7
      MODE_FOUR_TO_ONE: packWord = {up[3:0], lo}; // RULE9 RULE10
      default: packWord = up; // RULE8
    endcase
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // pin synchronisers: bit0 edge clock, 1 upper, 2 lower, 3 strobe

  logic [3:0] pins;
  logic [3:0] sync1_q;
  logic [3:0] sync2_q;
  logic [3:0] sync3_q;
  logic [3:0] level_q;
  logic [3:0] levelNow;
  logic [3:0] rise;
  logic edgeTick;
  logic strobeTick;

  assign pins = {writeStrobeQuarterPhase, lowerHalfLane, upperHalfLane,
                 fastEdgeClock};
  // a change counts only once stages two and three agree
  assign levelNow = (~(sync2_q ^ sync3_q) & sync3_q)
                  | ((sync2_q ^ sync3_q) & level_q);
  assign rise = levelNow & ~level_q;
  assign edgeTick = rise[0];
  assign strobeTick = rise[3];

  // three-stage chain, first stage feeds only the second
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      sync1_q <= 4'h0;
      sync2_q <= 4'h0;
      sync3_q <= 4'h0;
      level_q <= 4'h0;
    end
    else
    begin
      sync1_q <= pins;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
      level_q <= levelNow;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // tri-state register stage

  iotg_mode_t mode_q;
  logic memMode_q;
  logic sdrTs_q;
  logic memTs_q;

  // single rate flop captured every cycle
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      sdrTs_q <= 1'b0;
    else
      sdrTs_q <= tristateCtrlIn; // RULE1 RULE2
  end

  // memory-mode flop loads on the shifted strobe edge
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      memTs_q <= 1'b0;
    else if (strobeTick)
      memTs_q <= memoryModeTristateIn; // RULE3
  end

  // pad control; memory path exists on the right edge only
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      padTristate <= 1'b0;
    else if (RIGHT_EDGE && memMode_q)
      padTristate <= memTs_q; // RULE3
    else
      padTristate <= sdrTs_q; // RULE1
  end

  //////////////////////////////////////////////////////////////////////////
  // deserializer

  logic [7:0] shiftUp_q;
  logic [3:0] shiftLo_q;
  logic [3:0] bitCnt_q;
  logic alignPend_q;
  logic [7:0] nextUp;
  logic [3:0] nextLo;
  logic wordDone;
  logic [WORD_W-1:0] stageWord_q;
  logic stageValid_q;
  logic fifoInReady;
  logic overrun_q;

  // sampled data shares the latency of the edge clock
  assign nextUp = {shiftUp_q[6:0], levelNow[1]}; // RULE6
  assign nextLo = {shiftLo_q[2:0], levelNow[2]};
  assign wordDone = edgeTick && !alignPend_q
                  && (bitCnt_q == ratioOf(mode_q) - 4'd1);

  // align request waits for the next serial bit
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      alignPend_q <= 1'b0;
    else if (gearboxRst)
      alignPend_q <= 1'b0; // RULE13
    else if (wordAlignPulse)
      alignPend_q <= 1'b1; // RULE11
    else if (edgeTick)
      alignPend_q <= 1'b0;
  end

  // shift on each edge clock rise; a slipped bit is dropped
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      shiftUp_q <= 8'h00;
      shiftLo_q <= 4'h0;
      bitCnt_q <= 4'h0;
    end
    else if (gearboxRst)
    begin
      shiftUp_q <= 8'h00; // RULE13
      shiftLo_q <= 4'h0;
      bitCnt_q <= 4'h0;
    end
    else if (edgeTick && !alignPend_q) // RULE11
    begin
      shiftUp_q <= nextUp; // RULE4 RULE12
      shiftLo_q <= nextLo;
      if (wordDone)
        bitCnt_q <= 4'h0; // RULE5
      else
        bitCnt_q <= bitCnt_q + 4'd1;
    end
  end

  // one-word stage; a full fifo stalls it and drops the next word
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      stageWord_q <= '0;
      stageValid_q <= 1'b0;
    end
    else if (gearboxRst)
    begin
      stageWord_q <= '0;
      stageValid_q <= 1'b0;
    end
    else if (wordDone && (!stageValid_q || fifoInReady))
    begin
      stageWord_q <= WORD_W'(packWord(mode_q, nextUp, nextLo));
      stageValid_q <= 1'b1;
    end
    else if (fifoInReady)
      stageValid_q <= 1'b0;
  end

  //////////////////////////////////////////////////////////////////////////
  // fifo and core port

  logic fifoOutValid;
  logic fifoPop;
  logic [WORD_W-1:0] fifoHead;
  logic [LW-1:0] fifoLevel;

  assign fifoPop = fifoOutValid && (!parValid || parReady);

  iotg_fifo #(.WIDTH(WORD_W), .DEPTH(FIFO_DEPTH)) wordFifo
  (
    .clk(clk),
    .nrst(nrst),
    .clear(gearboxRst),
    .inValid(stageValid_q),
    .inReady(fifoInReady),
    .inData(stageWord_q),
    .outValid(fifoOutValid),
    .outReady(fifoPop),
    .outData(fifoHead),
    .level(fifoLevel)
  );

  // parallel word register toward the core
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      parWord <= '0;
      parValid <= 1'b0;
    end
    else if (gearboxRst)
    begin
      parWord <= '0; // RULE13
      parValid <= 1'b0;
    end
    else if (!parValid || parReady)
    begin
      parValid <= fifoOutValid; // RULE12
      if (fifoOutValid)
        parWord <= fifoHead;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // apb registers

  logic apbSetup;
  logic apbDone;
  logic isCtrl;
  logic isStat;
  logic isWcnt;
  logic [`IOTG_WCNT_W-1:0] wordCnt_q;
  logic lostWord;

  assign apbSetup = psel && penable && !pready;
  assign apbDone = psel && penable && pready;
  assign isCtrl = (paddr == `IOTG_CTRL_OFS);
  assign isStat = (paddr == `IOTG_STAT_OFS);
  assign isWcnt = (paddr == `IOTG_WCNT_OFS);
  assign lostWord = wordDone && stageValid_q && !fifoInReady;

  // one wait state: answer in the second access cycle
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end
    else
    begin
      pready <= apbSetup;
      pslverr <= apbSetup && !(isCtrl || isStat || isWcnt);
      prdata <= 32'h0000_0000;
      if (apbSetup && !pwrite)
      begin
        if (isCtrl)
          prdata <= {29'h0, memMode_q, mode_q};
        else if (isStat)
          prdata <= {24'h0, 4'(fifoLevel), 3'h0, overrun_q};
        else if (isWcnt)
          prdata <= {16'h0, wordCnt_q};
      end
    end
  end

  // control register steers mode and tri-state source
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      mode_q <= iotg_mode_t'(`IOTG_CTRL_MODE_RST);
      memMode_q <= `IOTG_CTRL_MEM_RST;
    end
    else if (apbDone && pwrite && isCtrl)
    begin
      mode_q <= iotg_mode_t'(
        pwdata[`IOTG_CTRL_MODE_MSB:`IOTG_CTRL_MODE_LSB]); // RULE5
      memMode_q <= pwdata[`IOTG_CTRL_MEM_BIT];
    end
  end

  // sticky overrun, write one clears, a new loss wins
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      overrun_q <= 1'b0;
    else if (lostWord)
      overrun_q <= 1'b1;
    else if (apbDone && pwrite && isStat && pwdata[`IOTG_STAT_OVR_BIT])
      overrun_q <= 1'b0;
  end

  // delivered word count, wraps, cleared by gearbox reset
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      wordCnt_q <= '0;
    else if (gearboxRst)
      wordCnt_q <= '0;
    else if (fifoPop)
      wordCnt_q <= wordCnt_q + 1'b1;
  end

endmodule
`default_nettype wire

// ===== iotg_gearbox_asserts.sv
// port checks for the gearbox top
// assumes it is bound into iotg_gearbox below
`timescale 1ns/1ps
`default_nettype none
`include "iotg_cfg.svh"
module iotg_gearbox_asserts
  #(
    parameter int WORD_W = 8
  )
  (
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // tri-state and core side
    input wire logic tristateCtrlIn,
    input wire logic padTristate,
    input wire logic gearboxRst,
    input wire logic [WORD_W-1:0] parWord,
    input wire logic parValid,
    input wire logic parReady
  );
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  logic [2:0] ctrl_q;
  // shadow of mode and memory-mode bits; only the pready edge commits a write
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      ctrl_q <= {`IOTG_CTRL_MEM_RST, `IOTG_CTRL_MODE_RST};
    else if (psel && penable && pready && pwrite
             && paddr == `IOTG_CTRL_OFS)
      ctrl_q <= pwdata[2:0];
  end
  //////////////////////////////////////////////////////////////////////////
  property p_triSdr;
    !ctrl_q[2] && !$past(ctrl_q[2]) && !$past(ctrl_q[2], 2)
      |-> padTristate == $past(tristateCtrlIn, 2);
  endproperty
  a_triSdr: assert property (p_triSdr)
    else $error("tri-state not two cycles behind");
  property p_sevenTop;
    ctrl_q[1:0] == 2'b00 && parValid |-> parWord[7] == 1'b0;
  endproperty
  a_sevenTop: assert property (p_sevenTop)
    else $error("top bit set in seven bit mode");
  property p_rstClear;
    gearboxRst |=> parWord == '0 && !parValid;
  endproperty
  a_rstClear: assert property (p_rstClear)
    else $error("gearbox reset left a word");
  property p_quiet;
    $fell(gearboxRst) |-> !parValid [*4];
  endproperty
  a_quiet: assert property (p_quiet)
    else $error("word out too soon after reset");
  property p_hold;
    parValid && !parReady && !gearboxRst |=> parValid && $stable(parWord);
  endproperty
  a_hold: assert property (p_hold)
    else $error("word dropped while stalled");
  property p_oneWait;
    psel && $rose(penable) |=> pready;
  endproperty
  a_oneWait: assert property (p_oneWait)
    else $error("apb answer not after one wait");
  property p_pulse;
    pready |=> !pready;
  endproperty
  a_pulse: assert property (p_pulse)
    else $error("pready longer than a cycle");
  property p_err;
    pready |-> pslverr == !(paddr inside {8'h00, 8'h04, 8'h08});
  endproperty
  a_err: assert property (p_err)
    else $error("slave error wrong for offset");
  property p_idle;
    !pready |-> prdata == 32'h0 && !pslverr;
  endproperty
  a_idle: assert property (p_idle)
    else $error("read bus not quiet");
  c_word: cover property (parValid && parReady);
  c_err: cover property (pready && pslverr);
  c_dual: cover property (ctrl_q[1:0] == 2'b10 && parValid);
endmodule
bind iotg_gearbox iotg_gearbox_asserts #(.WORD_W(WORD_W)) i_chk
  (
    .clk(clk), .nrst(nrst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .tristateCtrlIn(tristateCtrlIn),
    .padTristate(padTristate), .gearboxRst(gearboxRst),
    .parWord(parWord), .parValid(parValid), .parReady(parReady)
  );
`default_nettype wire

// ===== iotg_src.sv
// serial source model for the gearbox pins
// assumes callers start send just after a clk edge
`timescale 1ns/1ps
`default_nettype none
module iotg_src
  (
    // pins
    output logic edgeClk,
    output logic upLane,
    output logic loLane
  );
  // clock stands low between frames
  initial
  begin
    edgeClk = 1'b0;
    upLane = 1'b0;
    loLane = 1'b0;
  end
  // msb first, 200 ns per bit; 7 ns keeps edges off clk
  task automatic send(input logic [8:0] u, input logic [3:0] l,
    input int n);
    #7;
    for (int i = n - 1; i >= 0; i--)
    begin
      upLane = u[i];
      loLane = l[i % 4];
      #100 edgeClk = 1'b1;
      #100 edgeClk = 1'b0;
    end
    // released lanes must not look like the last bit
    upLane = ~upLane;
    loLane = ~loLane;
  endtask
endmodule
`default_nettype wire

// ===== test_io_tristate_reg_and_input_gearbox.sv
// bench for the tri-state stage and input gearbox
// assumes the checker and source model are compiled first
`timescale 1ns/1ps
`default_nettype none
module test_io_tristate_reg_and_input_gearbox;
  logic clk = 1'b0;
  logic nrst, psel, penable, pwrite, triIn, memIn, strobe;
  logic alignP, gbRst, parReady, pready, pslverr, padTri, parValid;
  logic edgeClk, upLane, loLane, err;
  logic [7:0] paddr, parWord;
  logic [31:0] pwdata, prdata, rd;
  int mismatches = 0;
  int compares = 0;
  always #12.5 clk = ~clk;
  iotg_gearbox i_dut
  (
    .clk(clk), .nrst(nrst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .tristateCtrlIn(triIn),
    .memoryModeTristateIn(memIn), .writeStrobeQuarterPhase(strobe),
    .padTristate(padTri), .fastEdgeClock(edgeClk),
    .upperHalfLane(upLane), .lowerHalfLane(loLane),
    .wordAlignPulse(alignP), .gearboxRst(gbRst), .parWord(parWord),
    .parValid(parValid), .parReady(parReady)
  );
  iotg_src i_src (.edgeClk(edgeClk), .upLane(upLane), .loLane(loLane));
  //////////////////////////////////////////////////////////////////////////
  task automatic end_sim;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic stop;
    mismatches++;
    $display("MISMATCH %0t wait ran out", $time);
    end_sim();
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      mismatches++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // one apb transfer; idle edge after it so back to back never clash
  task automatic apb(input logic w, input logic [7:0] a,
    input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1)
      stop();
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic waitV;
    int n;
    n = 0;
    while (parValid !== 1'b1 && n < 400)
    begin
      @(posedge clk);
      n++;
    end
    if (parValid !== 1'b1)
      stop();
  endtask
  task automatic take(input logic [7:0] e);
    waitV();
    chk(32'(parWord), 32'(e));
    parReady <= 1'b1;
    @(posedge clk);
    parReady <= 1'b0;
    @(posedge clk);
  endtask
  task automatic gbReset;
    gbRst <= 1'b1;
    repeat (2) @(posedge clk);
    gbRst <= 1'b0;
    @(posedge clk);
  endtask
  //////////////////////////////////////////////////////////////////////////
  // main sequence
  initial
  begin
    nrst = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    triIn = 1'b0;
    memIn = 1'b0;
    strobe = 1'b0;
    alignP = 1'b0;
    gbRst = 1'b0;
    parReady = 1'b0;
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    apb(1'b0, 8'h00, 32'h0);
    chk(rd, 32'h1);
    apb(1'b0, 8'h0c, 32'h0);
    chk({31'h0, err}, 32'h1);
    $display("registers done");
    triIn <= 1'b1;
    repeat (3) @(posedge clk);
    chk(32'(padTri), 32'h1);
    triIn <= 1'b0;
    repeat (3) @(posedge clk);
    chk(32'(padTri), 32'h0);
    apb(1'b1, 8'h00, 32'h5);
    memIn <= 1'b1;
    strobe <= 1'b1;
    repeat (8) @(posedge clk);
    chk(32'(padTri), 32'h1);
    memIn <= 1'b0;
    strobe <= 1'b0;
    repeat (8) @(posedge clk);
    chk(32'(padTri), 32'h1);
    apb(1'b1, 8'h00, 32'h1);
    $display("tristate done");
    i_src.send(9'h0a5, 4'h0, 8);
    take(8'ha5);
    apb(1'b0, 8'h08, 32'h0);
    chk(rd, 32'h1);
    alignP <= 1'b1;
    @(posedge clk);
    alignP <= 1'b0;
    i_src.send(9'h13c, 4'h0, 9);
    take(8'h3c);
    apb(1'b1, 8'h00, 32'h0);
    gbReset();
    i_src.send(9'h07f, 4'h0, 7);
    take(8'h7f);
    // leftover ones in the shifter must not leak into bit seven
    i_src.send(9'h05b, 4'h0, 7);
    take(8'h5b);
    apb(1'b1, 8'h00, 32'h2);
    gbReset();
    i_src.send(9'h00c, 4'h3, 4);
    take(8'hc3);
    $display("modes done");
    // core stalls until the buffer overflows; spare code acts as 1:8
    apb(1'b1, 8'h00, 32'h3);
    gbReset();
    for (int i = 0; i < 12; i++)
      i_src.send(9'(8'h10 + i), 4'h0, 8);
    // back onto a clk edge before driving the bus
    @(posedge clk);
    apb(1'b0, 8'h04, 32'h0);
    chk(rd & 32'hf1, 32'h81);
    for (int i = 0; i < 9; i++)
      take(8'(8'h10 + i));
    gbReset();
    apb(1'b0, 8'h04, 32'h0);
    chk(rd, 32'h1);
    apb(1'b1, 8'h04, 32'h1);
    apb(1'b0, 8'h04, 32'h0);
    chk(rd, 32'h0);
    i_src.send(9'h0ff, 4'h0, 8);
    waitV();
    gbRst <= 1'b1;
    repeat (2) @(posedge clk);
    chk(32'(parWord), 32'h0);
    chk(32'(parValid), 32'h0);
    gbRst <= 1'b0;
    $display("buffer done");
    end_sim();
  end
endmodule
`default_nettype wire
